/* rtl/pot_link_pkg.sv */
// constants shared by both ends of the quad potentiometer two-wire link
// assumes a 25 MHz system clock on both ends and a pulled-up data line
`default_nettype none

package pot_link_pkg;
   // device type nibble of the slave address; value is arbitrary
   localparam logic [3:0]  DEV_TYPE_ID      = 4'ha;
   // instruction opcodes in the upper nibble of the command byte
   localparam logic [3:0]  OP_WR_WIPER      = 4'ha;
   localparam logic [3:0]  OP_WR_DATA       = 4'hc;
   localparam logic [3:0]  OP_DATA_TO_WIPER = 4'hd;
   localparam logic [3:0]  OP_WIPER_TO_DATA = 4'he;
   localparam logic [3:0]  OP_ALL_TO_WIPER  = 4'h1;
   localparam logic [3:0]  OP_ALL_TO_DATA   = 4'h8;
   // command byte field positions
   localparam int          OPC_MSB          = 7;
   localparam int          OPC_LSB          = 4;
   localparam int          POT_MSB          = 3;
   localparam int          POT_LSB          = 2;
   localparam int          REG_MSB          = 1;
   localparam int          REG_LSB          = 0;
   // geometry
   localparam logic [3:0]  ACK_SLOT         = 4'h8;
   localparam int          POTS             = 4;
   localparam int          TAPS             = 64;
   localparam int          WIPER_W          = 6;
   localparam int          DREGS            = 16;
   // nonvolatile write time and its cycle count at the system clock
   localparam int          NVW_TIME_US      = 5000;
   localparam int          CLK_FREQ_MHZ     = 25;
   localparam int          NVW_CYCLES       = NVW_TIME_US * CLK_FREQ_MHZ;
   // host clock divider: four quarters of two cycles give 320 ns
   localparam logic [1:0]  SCL_QTR_LAST     = 2'h1;
   // host command word {has_data, command, data} and its queue
   localparam int          CMD_WORD_W       = 17;
   localparam int          CMD_FIFO_DEPTH   = 16;
   localparam int          HAS_DATA_BIT     = 16;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_ADDR = 2'b01,
      DEV_CMD  = 2'b10,
      DEV_DATA = 2'b11
   } dev_state_type;

   typedef enum logic [1:0] {
      HOST_IDLE  = 2'b00,
      HOST_START = 2'b01,
      HOST_BIT   = 2'b10,
      HOST_STOP  = 2'b11
   } host_state_type;
endpackage : pot_link_pkg

`default_nettype wire

/* rtl/two_wire_if.sv */
// two-wire link between host end and potentiometer end
// the data line is open drain; its level is resolved here from the enables
`default_nettype none

interface two_wire_if;
   logic scl;
   logic sda;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;

   // wired-and with a pull-up: any enabled low driver wins
   assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

   modport host   (output scl, output sda_host_o, output sda_host_oe, input sda);
   modport device (input scl, output sda_dev_o, output sda_dev_oe, input sda);
endinterface : two_wire_if

`default_nettype wire

/* rtl/pot_cmd_fifo.sv */
// command queue in front of the host link engine
// assumes one clock; pushing while full and popping while empty are ignored
`default_nettype none

module pot_cmd_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } fifo_regs_type;

   fifo_regs_type r_reg;
   fifo_regs_type r_next;
   logic          push;
   logic          pop;

   // full and empty come from the stored count, so ready never lies
   assign in_ready_o  = (r_reg.count != (AW+1)'(DEPTH));
   assign out_valid_o = (r_reg.count != '0);
   assign out_data_o  = r_reg.mem[r_reg.rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;

   // pointer and count update
   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.mem[r_reg.wr_ptr] = in_data_i;
         r_next.wr_ptr            = r_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         r_next.rd_ptr = r_reg.rd_ptr + 1'b1;
      end
      r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : pot_cmd_fifo

`default_nettype wire

/* rtl/pot_host_end.sv */
// bus master end: queues commands and plays them out on the two-wire link
// assumes the far end is the potentiometer slave; scl is made by a divider here
`default_nettype none

module pot_host_end (
   input  wire logic                                clk_sys_i,
   input  wire logic                                rst_i,
   input  wire logic [3:0]                          target_addr_i,
   input  wire logic                                cmd_valid_i,
   input  wire logic [pot_link_pkg::CMD_WORD_W-1:0] cmd_data_i,
   output logic                                     cmd_ready_o,
   output logic                                     done_o,
   output logic                                     nack_o,
   two_wire_if.host                                 bus
);
   typedef struct packed {
      pot_link_pkg::host_state_type  st;
      logic [1:0]                    cnt;
      logic [1:0]                    phase;
      logic [3:0]                    bitcnt;
      logic [1:0]                    byte_idx;
      logic [pot_link_pkg::CMD_WORD_W-1:0] word;
      logic [8:0]                    shreg;
      logic                          scl;
      logic                          pull;
      logic                          ack_ok;
      logic                          poll;
      logic                          failed;
      logic                          done;
      logic                          nack;
      logic                          sda1;
      logic                          sda2;
   } host_regs_type;

   host_regs_type                           r_reg;
   host_regs_type                           r_next;
   logic                                    q_valid;
   logic [pot_link_pkg::CMD_WORD_W-1:0]     q_data;
   logic                                    tick;

   pot_cmd_fifo #(
      .WIDTH (pot_link_pkg::CMD_WORD_W),
      .DEPTH (pot_link_pkg::CMD_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_valid_i  (cmd_valid_i),
      .in_data_i   (cmd_data_i),
      .in_ready_o  (cmd_ready_o),
      .out_valid_o (q_valid),
      .out_data_o  (q_data),
      .out_ready_i (r_reg.st == pot_link_pkg::HOST_IDLE)
   );

   assign tick = (r_reg.cnt == pot_link_pkg::SCL_QTR_LAST);

   // quarter-period sequencer for start, bits with ack slot, and stop
   always_comb begin
      r_next      = r_reg;
      r_next.sda1 = bus.sda;
      r_next.sda2 = r_reg.sda1;
      r_next.done = 1'b0;
      r_next.nack = 1'b0;
      r_next.cnt  = tick ? 2'h0 : r_reg.cnt + 2'h1;
      case (r_reg.st)
         pot_link_pkg::HOST_IDLE: begin
            r_next.cnt = 2'h0;
            if (q_valid) begin // each queued word starts here; a poll retry goes from stop straight to start
               r_next.word  = q_data;
               r_next.st    = pot_link_pkg::HOST_START;
               r_next.phase = 2'h0;
            end
         end
         pot_link_pkg::HOST_START: if (tick) begin
            r_next.phase = r_reg.phase + 2'h1;
            case (r_reg.phase)
               2'h0: begin
                  r_next.scl  = 1'b1;
                  r_next.pull = 1'b0;
               end
               2'h1: r_next.pull = 1'b1; // data falls while clock high
               2'h2: r_next.pull = 1'b1;
               default: begin
                  r_next.scl      = 1'b0;
                  r_next.st       = pot_link_pkg::HOST_BIT;
                  r_next.bitcnt   = 4'h0;
                  r_next.byte_idx = 2'h0;
                  r_next.shreg    = {pot_link_pkg::DEV_TYPE_ID, target_addr_i, 1'b1};
               end
            endcase
         end
         pot_link_pkg::HOST_BIT: if (tick) begin
            r_next.phase = r_reg.phase + 2'h1;
            case (r_reg.phase)
               2'h0: r_next.pull = ~r_reg.shreg[8]; // change only with clock low; ninth bit releases
               2'h1: r_next.scl  = 1'b1;
               2'h2: if (r_reg.bitcnt == pot_link_pkg::ACK_SLOT) begin
                  r_next.ack_ok = ~r_reg.sda2; // ninth clock carries the ack
               end
               default: begin
                  r_next.scl    = 1'b0;
                  r_next.shreg  = {r_reg.shreg[7:0], 1'b1};
                  r_next.bitcnt = r_reg.bitcnt + 4'h1;
                  if (r_reg.bitcnt == pot_link_pkg::ACK_SLOT) begin
                     r_next.bitcnt   = 4'h0;
                     r_next.byte_idx = r_reg.byte_idx + 2'h1;
                     if (!r_reg.ack_ok) begin
                        r_next.st     = pot_link_pkg::HOST_STOP;
                        r_next.poll   = (r_reg.byte_idx == 2'h0); // busy slave: poll again
                        r_next.failed = (r_reg.byte_idx != 2'h0);
                     end else if (r_reg.byte_idx == 2'h0) begin
                        r_next.shreg = {r_reg.word[15:8], 1'b1};
                     end else if (r_reg.byte_idx == 2'h1 && r_reg.word[pot_link_pkg::HAS_DATA_BIT]) begin
                        r_next.shreg = {r_reg.word[7:0], 1'b1};
                     end else begin
                        r_next.st = pot_link_pkg::HOST_STOP;
                     end
                  end
               end
            endcase
         end
         default: if (tick) begin // stop: data rises while clock high
            r_next.phase = r_reg.phase + 2'h1;
            case (r_reg.phase)
               2'h0: r_next.pull = 1'b1;
               2'h1: r_next.scl  = 1'b1;
               2'h2: r_next.pull = 1'b0;
               default: begin
                  r_next.poll   = 1'b0;
                  r_next.failed = 1'b0;
                  if (r_reg.poll) begin
                     r_next.st = pot_link_pkg::HOST_START;
                  end else begin
                     r_next.st   = pot_link_pkg::HOST_IDLE;
                     r_next.done = 1'b1;
                     r_next.nack = r_reg.failed;
                  end
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         r_reg      <= '0;
         r_reg.scl  <= 1'b1;
         r_reg.sda1 <= 1'b1;
         r_reg.sda2 <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.scl         = r_reg.scl;
   assign bus.sda_host_o  = 1'b0;
   assign bus.sda_host_oe = r_reg.pull;
   assign done_o          = r_reg.done;
   assign nack_o          = r_reg.nack;
endmodule : pot_host_end

`default_nettype wire

/* rtl/pot_device_end.sv */
// slave end of a quad digitally controlled potentiometer on a two-wire link
// assumes scl and sda come from the far end and are oversampled by clk_sys_i
`default_nettype none

module pot_device_end #(
   parameter int NVW_CYCLES = pot_link_pkg::NVW_CYCLES
) (
   input  wire logic                       clk_sys_i,
   input  wire logic                       rst_i,
   input  wire logic [3:0]                 device_addr_straps_i,
   two_wire_if.device                      bus,
   output logic [3:0][pot_link_pkg::TAPS-1:0]    tap_select_o,
   output logic [3:0][pot_link_pkg::WIPER_W-1:0] wiper_position_o,
   output logic                            nv_busy_o
);
   typedef struct packed {
      pot_link_pkg::dev_state_type            st;
      logic                                   scl1;
      logic                                   scl2;
      logic                                   scl3;
      logic                                   sda1;
      logic                                   sda2;
      logic                                   sda3;
      logic [3:0]                             strap1;
      logic [3:0]                             strap2;
      logic [3:0]                             bitcnt;
      logic                                   in_ack;
      logic                                   pull;
      logic [7:0]                             shreg;
      logic [7:0]                             cmd;
      logic [3:0][pot_link_pkg::WIPER_W-1:0]  wiper;
      logic [pot_link_pkg::DREGS-1:0][pot_link_pkg::WIPER_W-1:0] dreg;
      logic [3:0]                             nv_mask;
      logic [1:0]                             nv_reg;
      logic [3:0][pot_link_pkg::WIPER_W-1:0]  nv_val;
      logic                                   busy;
      logic [31:0]                            busy_cnt;
      logic [3:0][pot_link_pkg::TAPS-1:0]     tap;
   } dev_regs_type;

   dev_regs_type r_reg;
   dev_regs_type r_next;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_seen;
   logic         stop_seen;
   logic [3:0]   opc;
   logic [1:0]   pot;
   logic [1:0]   rsel;
   logic [3:0]   didx;

   // edges are taken after the second sync stage only
   assign scl_rise   = r_reg.scl2 & ~r_reg.scl3;
   assign scl_fall   = ~r_reg.scl2 & r_reg.scl3;
   assign start_seen = r_reg.scl2 & r_reg.scl3 & r_reg.sda3 & ~r_reg.sda2;
   assign stop_seen  = r_reg.scl2 & r_reg.scl3 & ~r_reg.sda3 & r_reg.sda2;

   // command byte fields, from the held command in the data phase
   always_comb begin
      opc  = r_reg.shreg[pot_link_pkg::OPC_MSB:pot_link_pkg::OPC_LSB];
      pot  = r_reg.shreg[pot_link_pkg::POT_MSB:pot_link_pkg::POT_LSB];
      rsel = r_reg.shreg[pot_link_pkg::REG_MSB:pot_link_pkg::REG_LSB];
      if (r_reg.st == pot_link_pkg::DEV_DATA) begin
         opc  = r_reg.cmd[pot_link_pkg::OPC_MSB:pot_link_pkg::OPC_LSB];
         pot  = r_reg.cmd[pot_link_pkg::POT_MSB:pot_link_pkg::POT_LSB];
         rsel = r_reg.cmd[pot_link_pkg::REG_MSB:pot_link_pkg::REG_LSB];
      end
      didx = {pot, rsel};
   end

   always_comb begin
      r_next        = r_reg;
      r_next.scl1   = bus.scl;
      r_next.scl2   = r_reg.scl1;
      r_next.scl3   = r_reg.scl2;
      r_next.sda1   = bus.sda;
      r_next.sda2   = r_reg.sda1;
      r_next.sda3   = r_reg.sda2;
      r_next.strap1 = device_addr_straps_i;
      r_next.strap2 = r_reg.strap1;

      // write timer; clearing busy re-enables the address ack
      if (r_reg.busy) begin
         r_next.busy_cnt = r_reg.busy_cnt - 32'h1;
         if (r_reg.busy_cnt == 32'h1) begin
            r_next.busy = 1'b0;
         end
      end

      if (start_seen) begin
         // a start anywhere aborts the byte and expects an address
         r_next.st     = pot_link_pkg::DEV_ADDR;
         r_next.bitcnt = 4'h0;
         r_next.in_ack = 1'b0;
         r_next.pull   = 1'b0;
      end else if (stop_seen) begin
         r_next.st     = pot_link_pkg::DEV_IDLE;
         r_next.in_ack = 1'b0;
         r_next.pull   = 1'b0;
         if (r_reg.nv_mask != 4'h0) begin
            // the store commits and the busy time begins at stop
            for (int p = 0; p < pot_link_pkg::POTS; p++) begin
               if (r_reg.nv_mask[p]) begin
                  r_next.dreg[{p[1:0], r_reg.nv_reg}] = r_reg.nv_val[p];
               end
            end
            r_next.nv_mask  = 4'h0;
            r_next.busy     = 1'b1;
            r_next.busy_cnt = 32'(NVW_CYCLES);
         end
      end else if (r_reg.st != pot_link_pkg::DEV_IDLE || r_reg.in_ack) begin
         if (scl_rise && r_reg.bitcnt != pot_link_pkg::ACK_SLOT) begin
            // sample on the rising clock, when data is stable
            r_next.shreg  = {r_reg.shreg[6:0], r_reg.sda2};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
         end else if (scl_fall && r_reg.in_ack) begin
            // ninth clock over: let go of the line
            r_next.in_ack = 1'b0;
            r_next.pull   = 1'b0;
            r_next.bitcnt = 4'h0;
         end else if (scl_fall && r_reg.bitcnt == pot_link_pkg::ACK_SLOT) begin
            r_next.in_ack = 1'b1;
            r_next.pull   = 1'b1; // low during the ninth clock
            r_next.st     = pot_link_pkg::DEV_IDLE;
            case (r_reg.st)
               pot_link_pkg::DEV_ADDR: begin
                  // type nibble, strap nibble, and not busy writing
                  if (r_reg.shreg == {pot_link_pkg::DEV_TYPE_ID, r_reg.strap2} && !r_reg.busy) begin
                     r_next.st = pot_link_pkg::DEV_CMD;
                  end else begin
                     r_next.in_ack = 1'b0; // mismatch: no ack, back to idle
                     r_next.pull   = 1'b0;
                  end
               end
               pot_link_pkg::DEV_CMD: begin
                  r_next.cmd = r_reg.shreg; // command byte held; acknowledged unless the opcode is unsupported
                  case (opc)
                     pot_link_pkg::OP_WR_WIPER,
                     pot_link_pkg::OP_WR_DATA: r_next.st = pot_link_pkg::DEV_DATA;
                     pot_link_pkg::OP_DATA_TO_WIPER: r_next.wiper[pot] = r_reg.dreg[didx];
                     pot_link_pkg::OP_WIPER_TO_DATA: begin
                        r_next.nv_mask      = 4'h0;
                        r_next.nv_mask[pot] = 1'b1;
                        r_next.nv_reg       = rsel;
                        r_next.nv_val[pot]  = r_reg.wiper[pot];
                     end
                     pot_link_pkg::OP_ALL_TO_WIPER: begin
                        for (int p = 0; p < pot_link_pkg::POTS; p++) begin
                           r_next.wiper[p] = r_reg.dreg[{p[1:0], rsel}];
                        end
                     end
                     pot_link_pkg::OP_ALL_TO_DATA: begin
                        r_next.nv_mask = 4'hf;
                        r_next.nv_reg  = rsel;
                        r_next.nv_val  = r_reg.wiper;
                     end
                     default: begin
                        // unsupported opcode is left unacknowledged
                        r_next.in_ack = 1'b0;
                        r_next.pull   = 1'b0;
                     end
                  endcase
               end
               pot_link_pkg::DEV_DATA: begin
                  // data byte acknowledged; further bytes are ignored
                  if (opc == pot_link_pkg::OP_WR_WIPER) begin
                     r_next.wiper[pot] = r_reg.shreg[pot_link_pkg::WIPER_W-1:0];
                  end else begin
                     r_next.nv_mask      = 4'h0;
                     r_next.nv_mask[pot] = 1'b1;
                     r_next.nv_reg       = rsel;
                     r_next.nv_val[pot]  = r_reg.shreg[pot_link_pkg::WIPER_W-1:0];
                  end
               end
               default: begin
                  r_next.in_ack = 1'b0;
                  r_next.pull   = 1'b0;
               end
            endcase
         end
      end

      // one-hot decode from the next wiper, so taps track it with no lag
      for (int p = 0; p < pot_link_pkg::POTS; p++) begin
         r_next.tap[p] = 64'h1 << r_next.wiper[p];
      end
   end

   // sync stages reset high so an idle bus never looks like a start
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         r_reg      <= '0;
         r_reg.scl1 <= 1'b1;
         r_reg.scl2 <= 1'b1;
         r_reg.scl3 <= 1'b1;
         r_reg.sda1 <= 1'b1;
         r_reg.sda2 <= 1'b1;
         r_reg.sda3 <= 1'b1;
         r_reg.tap  <= {4{64'h1}};
      end else begin
         r_reg <= r_next;
      end
   end

   // open drain: the output value is always low, only the enable moves
   assign bus.sda_dev_o     = 1'b0;
   assign bus.sda_dev_oe    = r_reg.pull;
   assign tap_select_o      = r_reg.tap;
   assign wiper_position_o  = r_reg.wiper;
   assign nv_busy_o         = r_reg.busy;
endmodule : pot_device_end

`default_nettype wire

/* bench/pot_link_checker.sv */
// checker on the two-wire link between host end and device end
// assumes scl halves of 4 clocks, as the host divider makes them
`default_nettype none
module pot_link_checker (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // framing edges seen on the resolved line; the ack seen on the device enable
   sequence start_s; scl && $fell(sda); endsequence
   sequence stop_s; scl && $rose(sda); endsequence
   sequence ack_s; $rose(sda_dev_oe); endsequence
   a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_o) else $error("device drives high");
   a_host_open_drain: assert property (sda_host_oe |-> !sda_host_o) else $error("host drives high");
   a_dev_edge_low: assert property ($changed(sda_dev_oe) |-> !scl) else $error("device edge in scl high");
   a_ack_holds: assert property (ack_s |-> sda_dev_oe[*6]) else $error("ack too short");
   a_ack_ends: assert property (ack_s |-> ##[6:12] $fell(sda_dev_oe)) else $error("ack too long");
   a_host_yields: assert property (sda_dev_oe && scl |-> !sda_host_oe) else $error("host holds ack slot");
   a_stop_release: assert property (stop_s |=> !sda_dev_oe[*8]) else $error("device pulls after stop");
   a_start_restart: assert property (start_s |=> !sda_dev_oe[*8]) else $error("device pulls after start");
   a_stop_scl_high: assert property (stop_s |-> scl[*4]) else $error("scl drops after stop");
endmodule : pot_link_checker
`default_nettype wire

/* bench/quad_pot_two_wire_slave_tb_top.sv */
// host end drives device end; words queued, checked as done_o pulses
// assumes pulled-up sda resolved in the interface; nv write shortened
`default_nettype none
module quad_pot_two_wire_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_sys_i = 1'b0;
   logic             rst_i = 1'b1;
   logic [3:0]       target_addr_i = 4'h5;
   logic [3:0]       straps = 4'h5;
   logic             cmd_valid_i = 1'b0;
   logic [16:0]      cmd_data_i = 17'h0;
   logic             cmd_ready_o, done_o, nack_o, nv_busy_o;
   logic [3:0][63:0] tap_select_o;
   logic [3:0][5:0]  wiper_position_o;
   logic [5:0]       wmod [4] = '{default: 6'h0};
   logic [5:0]       dmod [16] = '{default: 6'h0};
   logic [8:0]       exp_q [$];
   logic [8:0]       nt;
   logic [5:0]       o;
   logic [1:0]       pt;
   int               err_count = 0;
   int               tests_run = 0;
   int               cycles = 0;
   two_wire_if link ();
   pot_host_end pot_host_end_i (.clk_sys_i, .rst_i, .target_addr_i, .cmd_valid_i, .cmd_data_i, .cmd_ready_o,
      .done_o, .nack_o, .bus(link));
   pot_device_end #(.NVW_CYCLES(200)) pot_device_end_i (.clk_sys_i, .rst_i, .device_addr_straps_i(straps),
      .bus(link), .tap_select_o, .wiper_position_o, .nv_busy_o);
   pot_link_checker pot_link_checker_i (.clk_sys_i, .rst_i, .scl(link.scl), .sda(link.sda),
      .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
      .sda_dev_oe(link.sda_dev_oe));
   always #20 clk_sys_i = ~clk_sys_i;
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // valid stays up so pushes can run back to back; a refused word is not noted
   task automatic push(input logic [3:0] op, input logic [1:0] p, input logic [1:0] r, input logic [5:0] v,
                       input logic hd, input logic nk);
      logic tk;
      tk = cmd_ready_o;
      cmd_valid_i = 1'b1;
      cmd_data_i = {hd, op, p, r, 2'h0, v};
      @(posedge clk_sys_i);
      #1;
      if (tk && op == pot_link_pkg::OP_WR_WIPER) wmod[p] = v;
      if (tk && op == pot_link_pkg::OP_WR_DATA) dmod[{p, r}] = v;
      if (tk && op == pot_link_pkg::OP_DATA_TO_WIPER) wmod[p] = dmod[{p, r}];
      if (tk && op == pot_link_pkg::OP_WIPER_TO_DATA) dmod[{p, r}] = wmod[p];
      for (int q = 0; q < 4; q++) begin
         if (tk && op == pot_link_pkg::OP_ALL_TO_DATA) dmod[{q[1:0], r}] = wmod[q];
         if (tk && op == pot_link_pkg::OP_ALL_TO_WIPER) wmod[q] = dmod[{q[1:0], r}];
      end
      if (tk) exp_q.push_back({nk, p, wmod[p]});
   endtask : push
   task automatic drain(input string nm);
      cmd_valid_i = 1'b0;
      while (exp_q.size() != 0) @(posedge clk_sys_i);
      #1;
      $display("test %s finished", nm);
   endtask : drain
   // hang guard, well above the longest expected run
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         wrap_up();
      end
   end
   // done pulse spans a falling edge, so results are read there
   always @(negedge clk_sys_i) begin
      if (!rst_i && done_o === 1'b1) begin
         if (exp_q.size() == 0) cmp(64'h1, 64'h0);
         else begin
            nt = exp_q.pop_front();
            cmp(64'(nack_o), 64'(nt[8]));
            cmp(64'(wiper_position_o[nt[7:6]]), 64'(nt[5:0]));
            cmp(tap_select_o[nt[7:6]], 64'h1 << nt[5:0]);
         end
      end
   end
   initial begin
      void'($urandom(53506));
      repeat (4) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      for (int p = 0; p < 4; p++) push(pot_link_pkg::OP_WR_WIPER, p[1:0], 2'h0, 6'($urandom), 1'b1, 1'b0);
      drain("direct wipers");
      // one strap bit off: host polls until the straps agree
      straps = 4'h5 ^ 4'(1 << ($urandom % 4));
      o = wmod[2];
      push(pot_link_pkg::OP_WR_WIPER, 2'h2, 2'h0, ~o, 1'b1, 1'b0);
      cmd_valid_i = 1'b0;
      repeat (600) @(posedge clk_sys_i);
      #1;
      cmp(64'(wiper_position_o[2]), 64'(o));
      straps = 4'h5;
      drain("strap mismatch");
      pt = 2'($urandom);
      o = wmod[pt];
      push(pot_link_pkg::OP_WR_DATA, pt, 2'($urandom), ~o, 1'b1, 1'b0);
      push(pot_link_pkg::OP_DATA_TO_WIPER, pt, cmd_data_i[9:8], 6'h0, 1'b0, 1'b0);
      cmd_valid_i = 1'b0;
      for (int i = 0; i < 2000 && nv_busy_o !== 1'b1; i++) @(posedge clk_sys_i);
      // look late in the busy time, so an ack given while busy would have moved the wiper
      repeat (180) @(posedge clk_sys_i);
      #1;
      cmp(64'(nv_busy_o), 64'h1);
      cmp(64'(wiper_position_o[pt]), 64'(o));
      drain("nv write then poll");
      push(4'h9, 2'h1, 2'h0, 6'h0, 1'b0, 1'b1);
      drain("unsupported opcode");
      // snapshot all, store one, overwrite, then recall one and all
      push(pot_link_pkg::OP_ALL_TO_DATA, 2'h0, 2'h2, 6'h0, 1'b0, 1'b0);
      push(pot_link_pkg::OP_WR_WIPER, 2'h3, 2'h0, 6'($urandom), 1'b1, 1'b0);
      push(pot_link_pkg::OP_WIPER_TO_DATA, 2'h3, 2'h1, 6'h0, 1'b0, 1'b0);
      push(pot_link_pkg::OP_WR_WIPER, 2'h3, 2'h0, 6'($urandom), 1'b1, 1'b0);
      push(pot_link_pkg::OP_DATA_TO_WIPER, 2'h3, 2'h1, 6'h0, 1'b0, 1'b0);
      push(pot_link_pkg::OP_ALL_TO_WIPER, 2'h3, 2'h2, 6'h0, 1'b0, 1'b0);
      drain("register transfers");
      for (int i = 0; i < 20; i++) push(pot_link_pkg::OP_WR_WIPER, 2'($urandom), 2'h0, 6'($urandom), 1'b1, 1'b0);
      cmp(64'(cmd_ready_o), 64'h0);
      drain("queue fill");
      wrap_up();
   end
endmodule : quad_pot_two_wire_slave_tb_top
`default_nettype wire
